//--- mia_pkg.sv
package mia_pkg;
    // timing
    localparam int          CLK_PERIOD_NS    = 5;
    localparam int          T_INSTR_NS       = 1000;
    localparam int          INSTR_CLKS       = (T_INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          ACK_INSTR_CYCLES = 7;
    localparam int          DIV_W            = 16;
    // vectoring
    localparam int          N_SRC            = 16;
    localparam logic [3:0]  TRAP_IDX         = 4'hF;
    localparam logic [14:0] SERVICE_ADDR     = 15'h00FF;
    localparam logic [7:0]  VEC_BASE         = 8'hE0;
    localparam logic [7:0]  BLOCK_LAST       = 8'hFF;
    localparam logic [15:0] MASKABLE         = 16'h3EFE;
    // register map, byte addresses
    localparam int          ADR_W            = 8;
    localparam logic [7:0]  REG_ENABLE       = 8'h00;
    localparam logic [7:0]  REG_PENDING      = 8'h04;
    localparam logic [7:0]  REG_STATUS       = 8'h08;
    localparam logic [7:0]  REG_VECTOR       = 8'h0C;
    localparam int          STAT_GIE         = 0;
    localparam int          STAT_NMI         = 1;
    localparam int          STAT_TRAP        = 2;
    localparam logic [15:0] ENABLE_RST       = 16'h0000;
    localparam logic [15:0] PENDING_RST      = 16'h0000;
    localparam logic [7:0]  VECTOR_RST       = 8'hE0;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ACK  = 5'h02,
        ST_VHI  = 5'h04,
        ST_VLO  = 5'h08,
        ST_POP  = 5'h10
    } mia_state_t;

    typedef struct packed {
        logic        instr_start;
        logic        skip_pending;
        logic [14:0] ret_pc;
        logic        vis_exec;
        logic [14:0] vis_pc;
        logic        return_from_irq_instruction_exec;
        logic        trap_exec;
        logic        mem_rvalid;
        logic [7:0]  mem_rdata;
        logic        stack_rvalid;
        logic [14:0] stack_rdata;
    } mia_core_in_t;

    typedef struct packed {
        logic        irq_take;
        logic        busy;
        logic        stack_push;
        logic [14:0] stack_wdata;
        logic        stack_pop;
        logic        mem_rd;
        logic [14:0] mem_addr;
        logic        pc_load;
        logic [14:0] pc_value;
    } mia_core_out_t;

    typedef struct packed {
        mia_state_t     st;
        logic [15:0]    enable;
        logic [15:0]    pending;
        logic           global_irq_enable;
        logic           nmi_active;
        logic           trap_pend;
        logic [DIV_W-1:0] div_cnt;
        logic [2:0]     ack_cnt;
        logic [14:0]    vec_addr;
        logic [6:0]     vec_hi;
        logic [7:0]     last_vec;
        mia_core_out_t  out;
        logic           wb_ack;
        logic [31:0]    wb_dat;
    } mia_regs_t;
endpackage

//--- mia_irq_arbiter.sv
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - only sources 1-7 and 9-13 have software enable and pending
// - source event sets its pending flag
// - take needs enable, global enable, no trap service
// - evaluate only at instruction start, after skip
// - simultaneous sources: highest priority first
// - reset clears pending, enables, global enable
// - active means enabled and pending; immediate take
// - acknowledge clears global enable at start
// - push return address, then jump 00FF
// - acknowledge lasts seven instruction cycles
// - software global enable write takes effect immediately
// - return sets global enable, pops, loads pc
// - pending work taken right after return
// - vector select jumps through winner's table entry
// - sixteen two-byte vectors, top of block
// - select at block end uses next block
// - high byte first, fifteen-bit target
// - lowest rank at E0, trap at FE
// - even low byte E0..FE replaces pc low
// - nothing active: default lowest vector
// - fixed rank order, trap highest, default lowest
module mia_irq_arbiter #(
    parameter int INSTR_CLKS = mia_pkg::INSTR_CLKS
) (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [mia_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic [15:0]           event_in,
    input  wire mia_pkg::mia_core_in_t core_in,
    output mia_pkg::mia_core_out_t     core_out
);
    localparam int ACK_TOTAL = mia_pkg::ACK_INSTR_CYCLES * INSTR_CLKS;
    localparam logic [mia_pkg::DIV_W-1:0] DIV_LAST = mia_pkg::DIV_W'(INSTR_CLKS - 1);
    localparam logic [2:0] ACK_LAST = 3'(mia_pkg::ACK_INSTR_CYCLES - 1);

    generate
        if (INSTR_CLKS < 1 || INSTR_CLKS > 65535) begin : g_bad_div
            $error("INSTR_CLKS out of range");
        end
    endgenerate

    mia_pkg::mia_regs_t s;
    mia_pkg::mia_regs_t n;

    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    function automatic logic [3:0] top_idx(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 1; i < 16; i++) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    logic        tick;
    logic        bus_req;
    logic        boundary;
    logic [15:0] ev_m;
    logic [15:0] active;
    logic [3:0]  win;
    logic [7:0]  vec_lo;
    logic [6:0]  blk_hi;
    logic        take_mask;
    logic        take_trap;

    assign wb_dat_o = s.wb_dat;
    assign wb_ack_o = s.wb_ack;
    assign core_out = s.out;

    always_comb begin
        n = s;
        n.out.irq_take   = 1'b0;
        n.out.stack_push = 1'b0;
        n.out.stack_pop  = 1'b0;
        n.out.mem_rd     = 1'b0;
        n.out.pc_load    = 1'b0;
        n.wb_ack         = 1'b0;
        tick     = (s.div_cnt == DIV_LAST);
        n.div_cnt = tick ? '0 : s.div_cnt + 1'b1;
        bus_req  = wb_cyc_i && wb_stb_i && !s.wb_ack;
        boundary = core_in.instr_start && !core_in.skip_pending;
        ev_m     = event_in & mia_pkg::MASKABLE;
        // active set with trap at the top rank
        active   = (s.enable & s.pending & mia_pkg::MASKABLE) | {s.trap_pend, 15'h0000};
        win      = top_idx(active);
        vec_lo   = mia_pkg::VEC_BASE + {3'b000, win, 1'b0};
        blk_hi   = core_in.vis_pc[14:8] + {6'h00, core_in.vis_pc[7:0] == mia_pkg::BLOCK_LAST};
        take_trap = s.trap_pend && !s.nmi_active;
        take_mask = s.global_irq_enable && !s.nmi_active && (|(s.enable & s.pending & mia_pkg::MASKABLE));

        // register bus
        if (bus_req) begin
            n.wb_ack = 1'b1;
            n.wb_dat = 32'h0000_0000;
            unique case (wb_adr_i)
                mia_pkg::REG_ENABLE: begin
                    n.wb_dat = {16'h0000, s.enable};
                    if (wb_we_i) begin
                        n.enable = wr16(s.enable, wb_dat_i, wb_sel_i) & mia_pkg::MASKABLE;
                    end
                end
                mia_pkg::REG_PENDING: begin
                    n.wb_dat = {16'h0000, s.pending};
                    if (wb_we_i) begin
                        n.pending = wr16(s.pending, wb_dat_i, wb_sel_i) & mia_pkg::MASKABLE;
                    end
                end
                mia_pkg::REG_STATUS: begin
                    n.wb_dat[mia_pkg::STAT_GIE]  = s.global_irq_enable;
                    n.wb_dat[mia_pkg::STAT_NMI]  = s.nmi_active;
                    n.wb_dat[mia_pkg::STAT_TRAP] = s.trap_pend;
                    if (wb_we_i && wb_sel_i[0]) begin
                        n.global_irq_enable = wb_dat_i[mia_pkg::STAT_GIE];
                    end
                end
                mia_pkg::REG_VECTOR: begin
                    n.wb_dat = {24'h000000, s.last_vec};
                end
                default: begin
                    n.wb_dat = 32'h0000_0000;
                end
            endcase
        end

        // events win over a software clear in the same cycle
        n.pending = n.pending | ev_m;
        if (core_in.trap_exec) begin
            n.trap_pend = 1'b1;
        end

        unique case (s.st)
            mia_pkg::ST_IDLE: begin
                if (boundary && (take_trap || take_mask)) begin
                    n.global_irq_enable            = 1'b0;
                    n.nmi_active     = s.nmi_active || take_trap;
                    n.out.irq_take   = 1'b1;
                    n.out.stack_push = 1'b1;
                    n.out.stack_wdata = core_in.ret_pc;
                    n.out.busy       = 1'b1;
                    n.div_cnt        = '0;
                    n.ack_cnt        = 3'h0;
                    n.st             = mia_pkg::ST_ACK;
                end else if (core_in.vis_exec) begin
                    n.last_vec      = vec_lo;
                    n.vec_addr      = {blk_hi, vec_lo};
                    n.out.mem_rd    = 1'b1;
                    n.out.mem_addr  = {blk_hi, vec_lo};
                    n.out.busy      = 1'b1;
                    n.st            = mia_pkg::ST_VHI;
                end else if (core_in.return_from_irq_instruction_exec) begin
                    n.global_irq_enable           = 1'b1;
                    if (s.nmi_active) begin
                        n.nmi_active = 1'b0;
                        n.trap_pend  = core_in.trap_exec;
                    end
                    n.out.stack_pop = 1'b1;
                    n.out.busy      = 1'b1;
                    n.st            = mia_pkg::ST_POP;
                end
            end
            mia_pkg::ST_ACK: begin
                if (tick) begin
                    n.ack_cnt = s.ack_cnt + 3'h1;
                    if (s.ack_cnt == ACK_LAST) begin
                        n.out.pc_load  = 1'b1;
                        n.out.pc_value = mia_pkg::SERVICE_ADDR;
                        n.out.busy     = 1'b0;
                        n.st           = mia_pkg::ST_IDLE;
                    end
                end
            end
            mia_pkg::ST_VHI: begin
                if (core_in.mem_rvalid) begin
                    n.vec_hi       = core_in.mem_rdata[6:0];
                    n.out.mem_rd   = 1'b1;
                    n.out.mem_addr = s.vec_addr + 15'h0001;
                    n.st           = mia_pkg::ST_VLO;
                end
            end
            mia_pkg::ST_VLO: begin
                if (core_in.mem_rvalid) begin
                    n.out.pc_load  = 1'b1;
                    n.out.pc_value = {s.vec_hi, core_in.mem_rdata};
                    n.out.busy     = 1'b0;
                    n.st           = mia_pkg::ST_IDLE;
                end
            end
            mia_pkg::ST_POP: begin
                if (core_in.stack_rvalid) begin
                    n.out.pc_load  = 1'b1;
                    n.out.pc_value = core_in.stack_rdata;
                    n.out.busy     = 1'b0;
                    n.st           = mia_pkg::ST_IDLE;
                end
            end
            default: begin
                n.st       = mia_pkg::ST_IDLE;
                n.out.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s            <= '0;
            s.st         <= mia_pkg::ST_IDLE;
            s.enable     <= mia_pkg::ENABLE_RST;
            s.pending    <= mia_pkg::PENDING_RST;
            s.global_irq_enable        <= 1'b0;
            s.last_vec   <= mia_pkg::VECTOR_RST;
        end else begin
            s <= n;
        end
    end

    // checking
    logic [31:0] ack_clk;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ack_clk <= 32'h0000_0000;
        end else begin
            ack_clk <= (s.st == mia_pkg::ST_ACK) ? ack_clk + 32'h0000_0001 : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_vis_start;
        (s.st == mia_pkg::ST_IDLE) && core_in.vis_exec && !(boundary && (take_trap || take_mask));
    endsequence

    property p_event_sets;
        (|ev_m) |=> ((s.pending & $past(ev_m)) == $past(ev_m));
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event did not set pending");

    property p_take_at_boundary;
        s.out.irq_take |-> $past(boundary);
    endproperty
    a_take_at_boundary: assert property (p_take_at_boundary) else $error("take outside boundary");

    property p_take_gated;
        (boundary && (s.st == mia_pkg::ST_IDLE) && !s.global_irq_enable && !s.trap_pend) |=> !s.out.irq_take;
    endproperty
    a_take_gated: assert property (p_take_gated) else $error("take with global enable clear");

    property p_take_clears_gie;
        s.out.irq_take |-> (!s.global_irq_enable && s.out.stack_push && (s.out.stack_wdata == $past(core_in.ret_pc)));
    endproperty
    a_take_clears_gie: assert property (p_take_clears_gie) else $error("acknowledge start wrong");

    property p_ack_seven;
        (s.out.pc_load && (ack_clk != 32'h0000_0000)) |-> (ack_clk == ACK_TOTAL) && (s.out.pc_value == 15'h00FF);
    endproperty
    a_ack_seven: assert property (p_ack_seven) else $error("acknowledge length wrong");

    property p_return_from_irq_instruction;
        ((s.st == mia_pkg::ST_IDLE) && core_in.return_from_irq_instruction_exec && !(boundary && (take_trap || take_mask)))
            |=> (s.global_irq_enable && s.out.stack_pop);
    endproperty
    a_return_from_irq_instruction: assert property (p_return_from_irq_instruction) else $error("return did not set enable and pop");

    property p_vis_trap;
        (s_vis_start and s.trap_pend) |=> (s.last_vec == 8'hFE);
    endproperty
    a_vis_trap: assert property (p_vis_trap) else $error("trap vector not chosen");

    property p_vis_default;
        (s_vis_start and (active == 16'h0000)) |=> (s.last_vec == 8'hE0);
    endproperty
    a_vis_default: assert property (p_vis_default) else $error("default vector not chosen");

    property p_vis_even;
        s_vis_start |=> (!s.last_vec[0] && (s.last_vec >= 8'hE0) && s.out.mem_rd);
    endproperty
    a_vis_even: assert property (p_vis_even) else $error("vector byte not even E0..FE");

    property p_gie_write;
        (bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == mia_pkg::REG_STATUS) && wb_dat_i[0]
            && !((s.st == mia_pkg::ST_IDLE) && boundary && (take_trap || take_mask))) |=> s.global_irq_enable;
    endproperty
    a_gie_write: assert property (p_gie_write) else $error("enable write not honoured");

    sequence s_first_byte;
        (s.st == mia_pkg::ST_VHI) && core_in.mem_rvalid;
    endsequence

    sequence s_second_byte;
        (s.st == mia_pkg::ST_VLO) && core_in.mem_rvalid;
    endsequence

    sequence s_pop_done;
        (s.st == mia_pkg::ST_POP) && core_in.stack_rvalid;
    endsequence

    property p_wb_answer;
        bus_req |=> s.wb_ack;
    endproperty
    a_wb_answer: assert property (p_wb_answer) else $error("bus request not acknowledged");

    property p_wb_single;
        s.wb_ack |=> !s.wb_ack;
    endproperty
    a_wb_single: assert property (p_wb_single) else $error("bus acknowledge longer than one cycle");

    property p_mask_bits;
        ((s.enable | s.pending) & ~mia_pkg::MASKABLE) == 16'h0000;
    endproperty
    a_mask_bits: assert property (p_mask_bits) else $error("unmapped enable or pending bit set");

    property p_busy_ack;
        (s.st == mia_pkg::ST_ACK) |-> s.out.busy;
    endproperty
    a_busy_ack: assert property (p_busy_ack) else $error("busy low during acknowledge");

    property p_trap_blocks;
        (boundary && (s.st == mia_pkg::ST_IDLE) && s.nmi_active) |=> !s.out.irq_take;
    endproperty
    a_trap_blocks: assert property (p_trap_blocks) else $error("take during trap service");

    property p_take_mask;
        (boundary && (s.st == mia_pkg::ST_IDLE) && s.global_irq_enable && !s.nmi_active && (|(s.enable & s.pending))) |=> s.out.irq_take;
    endproperty
    a_take_mask: assert property (p_take_mask) else $error("active source not taken");

    property p_vis_block;
        s_vis_start |=> (s.out.mem_addr[14:8]
            == ($past(core_in.vis_pc[14:8]) + 7'($past(core_in.vis_pc[7:0]) == 8'hFF)));
    endproperty
    a_vis_block: assert property (p_vis_block) else $error("vector table block wrong");

    property p_vis_top;
        s_vis_start |=> (s.out.mem_addr[7:5] == 3'h7);
    endproperty
    a_vis_top: assert property (p_vis_top) else $error("vector table not at block top");

    property p_vis_next;
        s_first_byte |=> (s.out.mem_rd && (s.out.mem_addr == $past(s.out.mem_addr) + 15'h0001));
    endproperty
    a_vis_next: assert property (p_vis_next) else $error("second vector byte address wrong");

    property p_vis_load;
        s_second_byte |=> (s.out.pc_load && (s.out.pc_value[7:0] == $past(core_in.mem_rdata)) && !s.out.busy);
    endproperty
    a_vis_load: assert property (p_vis_load) else $error("vector low byte not loaded");

    property p_pop_load;
        s_pop_done |=> (s.out.pc_load && (s.out.pc_value == $past(core_in.stack_rdata)));
    endproperty
    a_pop_load: assert property (p_pop_load) else $error("popped address not loaded");
endmodule

//--- mia_core_model.sv
`timescale 1ns/1ps
module mia_core_model (
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire logic                   slow,
    input  wire mia_pkg::mia_core_out_t core_out,
    output logic                        mem_rvalid,
    output logic [7:0]                  mem_rdata,
    output logic                        stack_rvalid,
    output logic [14:0]                 stack_rdata
);
    logic [14:0] stack_q[$];
    logic [14:0] addr_q;
    int          mem_wait;
    int          stk_wait;
    // answers after one cycle, or several when slow; data lines toggle while idle
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            {mem_rvalid, mem_rdata, stack_rvalid, stack_rdata} <= '0;
            mem_wait <= 0;
            stk_wait <= 0;
            stack_q.delete();
        end else begin
            mem_rvalid <= 1'b0;
            stack_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
            stack_rdata <= ~stack_rdata;
            if (core_out.stack_push)
                stack_q.push_back(core_out.stack_wdata);
            if (core_out.mem_rd) begin
                addr_q <= core_out.mem_addr;
                mem_wait <= slow ? 4 : 1;
            end else if (mem_wait > 0) begin
                mem_wait <= mem_wait - 1;
                mem_rvalid <= (mem_wait == 1);
                if (mem_wait == 1) mem_rdata <= addr_q[7:0] ^ {1'b0, addr_q[14:8]} ^ 8'h3C;
            end
            if (core_out.stack_pop)
                stk_wait <= slow ? 3 : 1;
            else if (stk_wait > 0) begin
                stk_wait <= stk_wait - 1;
                stack_rvalid <= (stk_wait == 1);
                if (stk_wait == 1) stack_rdata <= stack_q.pop_back();
            end
        end
    end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int IC = 2;
    logic                   clk_sys, resetn, cyc, stb, we, ack, st, skip, vector_select_instruction, return_from_irq_instruction, trap, slow, mrv, srv, hit;
    logic [7:0]             adr, mrd;
    logic [3:0]             sel, wsel;
    logic [14:0]            ret_pc, vis_pc, srd, push_val, pc_seen, vpc;
    logic [15:0]            ev, en, pd;
    logic [31:0]            wdat, rdat, q;
    int                     takes, loads, gap, pc_gap, fail_count, samples_checked;
    mia_pkg::mia_core_in_t  core_in;
    mia_pkg::mia_core_out_t core_out;
    assign core_in = {st, skip, ret_pc, vector_select_instruction, vis_pc, return_from_irq_instruction, trap, mrv, mrd, srv, srd};
    mia_irq_arbiter #(.INSTR_CLKS(IC)) i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .event_in(ev), .core_in(core_in), .core_out(core_out));
    mia_core_model i_mem (
        .clk_sys(clk_sys), .resetn(resetn), .slow(slow), .core_out(core_out), .mem_rvalid(mrv),
        .mem_rdata(mrd), .stack_rvalid(srv), .stack_rdata(srd));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // counts take and load pulses and the cycles between them
    always @(posedge clk_sys) begin
        gap <= (core_out.irq_take === 1'b1) ? 0 : gap + 1;
        takes <= takes + int'(core_out.irq_take === 1'b1);
        if (core_out.stack_push === 1'b1) push_val <= core_out.stack_wdata;
        if (core_out.pc_load === 1'b1) begin
            loads <= loads + 1;
            pc_seen <= core_out.pc_value;
            pc_gap <= gap + 1;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, wsel};
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (ack === 1'b1) break;
        end
        q = rdat;
        {cyc, stb, we} <= 3'b000;
        if (n == 50) fail_count++;
    endtask
    task automatic pulse(input int w, input logic [14:0] pc);
        @(posedge clk_sys);
        {st, skip, vector_select_instruction, return_from_irq_instruction, trap} <= {w < 2, w == 1, w == 2, w == 3, w == 4};
        ret_pc <= pc;
        vis_pc <= pc;
        @(posedge clk_sys);
        {st, skip, vector_select_instruction, return_from_irq_instruction, trap} <= 5'h00;
    endtask
    task automatic await(input logic ld);
        int n0;
        n0 = ld ? loads : takes;
        hit = 1'b0;
        for (int i = 0; i < 40 && !hit; i++) begin
            @(negedge clk_sys);
            hit = (ld ? loads : takes) != n0;
        end
    endtask
    task automatic take(input int w, input logic [14:0] pc, input logic e);
        pulse(w, pc);
        await(1'b0);
        chk("take", 32'(e), 32'(hit));
        chk("busy", 32'(e), 32'(core_out.busy));
    endtask
    task automatic load(input int w, input logic [14:0] pc, input logic [14:0] e);
        if (w >= 0) pulse(w, pc);
        await(1'b1);
        chk("pc_load", 32'h1, 32'(hit));
        chk("pc_value", 32'(e), 32'(pc_seen));
        chk("busy", 32'h0, 32'(core_out.busy));
    endtask
    function automatic logic [7:0] mem_byte(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h3C;
    endfunction
    function automatic logic [14:0] vis_target(input logic [14:0] p, input logic [15:0] act, input logic tp);
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [14:0] a;
        lo = 8'hE0;
        for (int i = 1; i < 16; i++)
            if (act[i]) lo = 8'hE0 + 8'(2 * i);
        if (tp) lo = 8'hFE;
        a = {p[14:8] + 7'(p[7:0] == 8'hFF), lo};
        hi = mem_byte(a);
        return {hi[6:0], mem_byte(a + 15'h0001)};
    endfunction
    initial begin
        {resetn, cyc, stb, we, st, skip, vector_select_instruction, return_from_irq_instruction, trap, slow} = '0;
        {adr, wdat, ev, ret_pc, vis_pc} = '0;
        sel = 4'h0;
        wsel = 4'hF;
        fail_count = 0;
        samples_checked = 0;
        void'($urandom(32'h4402));
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, 8'(4 * i), 32'h0);
            chk("reset_value", (i == 3) ? 32'hE0 : 32'h0, q);
        end
        @(posedge clk_sys);
        ev <= 16'h2041;
        @(posedge clk_sys);
        ev <= 16'h0000;
        wb(1'b1, 8'h00, 32'hFFFF);
        wb(1'b0, 8'h00, 32'h0);
        chk("enable", 32'h3EFE, q);
        wsel = 4'h2;
        wb(1'b1, 8'h00, 32'h0);
        wsel = 4'hF;
        wb(1'b0, 8'h00, 32'h0);
        chk("enable_lane", 32'h00FE, q);
        wb(1'b1, 8'h00, 32'hFFFF);
        wb(1'b0, 8'h04, 32'h0);
        chk("pending", 32'h2040, q);
        take(0, 15'h1234, 1'b0);
        wb(1'b1, 8'h08, 32'h1);
        take(1, 15'h1234, 1'b0);
        take(0, 15'h1234, 1'b1);
        chk("pushed_pc", 32'h1234, 32'(push_val));
        wb(1'b0, 8'h08, 32'h0);
        chk("global_enable", 32'h0, q & 32'h1);
        load(-1, 15'h0, mia_pkg::SERVICE_ADDR);
        chk("ack_cycles", 7 * IC, pc_gap);
        load(2, 15'h00FF, vis_target(15'h00FF, 16'h2040, 1'b0));
        wb(1'b0, 8'h0C, 32'h0);
        chk("last_vector", 32'hFA, q);
        wb(1'b1, 8'h04, 32'h0040);
        load(3, 15'h0, 15'h1234);
        wb(1'b0, 8'h08, 32'h0);
        chk("global_enable", 32'h1, q & 32'h1);
        take(0, 15'h2345, 1'b1);
        load(-1, 15'h0, mia_pkg::SERVICE_ADDR);
        wb(1'b1, 8'h04, 32'h0);
        load(3, 15'h0, 15'h2345);
        for (int k = 0; k < 16; k++) begin
            en = 16'($urandom);
            pd = (k < 2) ? 16'h0000 : 16'($urandom);
            vpc = 15'($urandom);
            if (k % 3 == 0) vpc[7:0] = 8'hFF;
            slow <= 1'($urandom);
            wb(1'b1, 8'h00, 32'(en));
            wb(1'b1, 8'h04, 32'(pd));
            load(2, vpc, vis_target(vpc, en & pd & mia_pkg::MASKABLE, 1'b0));
        end
        wb(1'b1, 8'h00, 32'h2000);
        wb(1'b1, 8'h04, 32'h2000);
        wb(1'b1, 8'h08, 32'h0);
        pulse(4, 15'h0);
        take(0, 15'h0456, 1'b1);
        wb(1'b0, 8'h08, 32'h0);
        chk("status", 32'h6, q);
        load(-1, 15'h0, mia_pkg::SERVICE_ADDR);
        load(2, 15'h0123, vis_target(15'h0123, 16'h2000, 1'b1));
        wb(1'b1, 8'h08, 32'h1);
        take(0, 15'h0456, 1'b0);
        load(3, 15'h0, 15'h0456);
        take(0, 15'h0567, 1'b1);
        load(-1, 15'h0, mia_pkg::SERVICE_ADDR);
        give_verdict();
    end
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end
endmodule
